// *** pkg/ipsa_defs.vh ***
// Constants for the input pin signal assignment block
`ifndef IPSA_DEFS_VH
`define IPSA_DEFS_VH

// ************************************************************
// Register word indices
// ************************************************************
`define IPSA_REG_PIN3 4'h0
`define IPSA_REG_PIN5 4'h1
`define IPSA_REG_PIN6 4'h2
`define IPSA_REG_PIN7 4'h3
`define IPSA_REG_LIMIT 4'h4
`define IPSA_REG_CHG 4'h5
`define IPSA_REG_APPLY 4'h6
`define IPSA_REG_STATUS 4'h7
`define IPSA_REG_ACT_BASE 4'h8
`define IPSA_REG_ACT_LAST 4'hd

// ************************************************************
// Reset values of the selectors
// ************************************************************
`define IPSA_RST_PIN3 16'h0882
`define IPSA_RST_PIN5 16'h0995
`define IPSA_RST_PIN6 16'h0000
`define IPSA_RST_PIN7 16'h0000
`define IPSA_RST_LIMIT 16'h0403
`define IPSA_RST_CHG 16'h0000

// ************************************************************
// Field layout
// ************************************************************
`define IPSA_POS_CODE 3:0
`define IPSA_SPD_CODE 7:4
`define IPSA_FWD_PIN 7:0
`define IPSA_REV_PIN 15:8
`define IPSA_CHG_PIN 7:0
`define IPSA_APPLY_BIT 0

// ************************************************************
// Pin codes and fixed values
// ************************************************************
`define IPSA_PIN_NONE 8'h00
`define IPSA_PIN_CODE_BASE 8'h01
`define IPSA_PIN_IDX_6 2
`define IPSA_PIN_IDX_7 3
`define IPSA_FWD_HOME 8'h03
`define IPSA_REV_HOME 8'h04
`define IPSA_FUNC_NONE 4'h0
`define IPSA_LIMIT_IDLE 1'b1
`define IPSA_LEVEL_IDLE 1'b0

`endif

// *** src/ipsa_regs.v ***
// Programmed selector registers and read-back multiplexer
`timescale 1ns/1ps
`include "ipsa_defs.vh"

module ipsa_regs (
  clk,
  resetn,
  addr,
  wr_data,
  wr_en,
  rd_en,
  status,
  active_flat,
  prog_flat,
  apply_pulse,
  rd_data
);
  input wire clk;
  input wire resetn;
  input wire [3:0] addr;
  input wire [15:0] wr_data;
  input wire wr_en;
  input wire rd_en;
  input wire [15:0] status;
  input wire [95:0] active_flat;
  output wire [95:0] prog_flat;
  output reg apply_pulse;
  output reg [15:0] rd_data;

  reg [15:0] pin3_input_select_r;
  reg [15:0] pin5_input_select_r;
  reg [15:0] pin6_input_select_r;
  reg [15:0] pin7_input_select_r;
  reg [15:0] travel_limit_pin_select_r;
  reg [15:0] chg_pin_select_r;
  reg [15:0] rd_nxt;
  wire [3:0] act_idx;

  // ************************************************************
  // Register writes
  // ************************************************************
  // Programmed values only; the routing uses the latched copies
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin3_input_select_r <= `IPSA_RST_PIN3; // [RULE1]
      pin5_input_select_r <= `IPSA_RST_PIN5; // [RULE2]
      pin6_input_select_r <= `IPSA_RST_PIN6; // [RULE3]
      pin7_input_select_r <= `IPSA_RST_PIN7; // [RULE4]
      travel_limit_pin_select_r <= `IPSA_RST_LIMIT; // [RULE11]
      chg_pin_select_r <= `IPSA_RST_CHG;
      apply_pulse <= 1'b0;
    end else begin
      apply_pulse <= wr_en && (addr == `IPSA_REG_APPLY) &&
                     wr_data[`IPSA_APPLY_BIT]; // [RULE12]
      if (wr_en) begin
        case (addr)
          `IPSA_REG_PIN3: pin3_input_select_r <= wr_data;
          `IPSA_REG_PIN5: pin5_input_select_r <= wr_data;
          `IPSA_REG_PIN6: pin6_input_select_r <= wr_data;
          `IPSA_REG_PIN7: pin7_input_select_r <= wr_data;
          `IPSA_REG_LIMIT: travel_limit_pin_select_r <= wr_data;
          `IPSA_REG_CHG: chg_pin_select_r <= wr_data;
          default: ;
        endcase
      end
    end
  end

  assign prog_flat = {chg_pin_select_r, travel_limit_pin_select_r,
                      pin7_input_select_r, pin6_input_select_r,
                      pin5_input_select_r, pin3_input_select_r};
  assign act_idx = addr - `IPSA_REG_ACT_BASE;

  // ************************************************************
  // Read multiplexer, data one cycle after the strobe
  // ************************************************************
  always @* begin
    rd_nxt = 16'h0000;
    if (addr <= `IPSA_REG_CHG)
      rd_nxt = prog_flat[addr*16 +: 16];
    else if (addr == `IPSA_REG_STATUS)
      rd_nxt = status;
    else if (addr >= `IPSA_REG_ACT_BASE && addr <= `IPSA_REG_ACT_LAST)
      rd_nxt = active_flat[act_idx*16 +: 16];
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      rd_data <= 16'h0000;
    else if (rd_en)
      rd_data <= rd_nxt;
    else
      rd_data <= 16'h0000;
  end
endmodule

// *** src/ipsa_route.v ***
// Per-pin claim resolution between selector, limits and mode change
`timescale 1ns/1ps
`include "ipsa_defs.vh"

module ipsa_route #(
  parameter PIN_IDX = 0
) (
  sel,
  fwd_pin,
  rev_pin,
  chg_pin,
  speed_mode,
  func_code,
  fwd_take,
  rev_take,
  chg_take,
  sel_ignored
);
  input wire [15:0] sel;
  input wire [7:0] fwd_pin;
  input wire [7:0] rev_pin;
  input wire [7:0] chg_pin;
  input wire speed_mode;
  output wire [3:0] func_code;
  output wire fwd_take;
  output wire rev_take;
  output wire chg_take;
  output wire sel_ignored;

  localparam [7:0] MY_CODE = `IPSA_PIN_CODE_BASE + PIN_IDX[7:0];
  wire fwd_here;
  wire rev_here;
  wire fwd_yield;
  wire rev_yield;
  wire [3:0] mode_code;

  // ************************************************************
  // Claim decode
  // ************************************************************
  assign fwd_here = (fwd_pin == MY_CODE);
  // Reverse limit is dropped when it shares a pin with forward
  assign rev_here = (rev_pin == MY_CODE) && (rev_pin != fwd_pin); // [RULE10]
  // Limits parked on their home pins leave the selector in charge
  assign fwd_yield = (PIN_IDX == `IPSA_PIN_IDX_6) &&
                     (fwd_pin == `IPSA_FWD_HOME); // [RULE8]
  assign rev_yield = (PIN_IDX == `IPSA_PIN_IDX_7) &&
                     (rev_pin == `IPSA_REV_HOME); // [RULE9]
  assign fwd_take = fwd_here && !fwd_yield; // [RULE7]
  assign rev_take = rev_here && !rev_yield; // [RULE7]
  // Limit placement outranks the mode change assignment
  assign chg_take = (chg_pin == MY_CODE) && !fwd_take && !rev_take;
  assign sel_ignored = chg_take || fwd_take || rev_take; // [RULE5] [RULE6]
  assign mode_code = speed_mode ? sel[`IPSA_SPD_CODE] : sel[`IPSA_POS_CODE];
  assign func_code = sel_ignored ? `IPSA_FUNC_NONE : mode_code;
endmodule

// *** src/ipsa_top.v ***
// Input pin signal assignment: connector pin to logical function router
//
// Contract
// (RULE1) Pin 3 has a function selector whose reset value is 0882.
// (RULE2) Pin 5 has a function selector whose reset value is 0995.
// (RULE3) Pin 6 has a function selector whose reset value is 0000.
// (RULE4) Pin 7 has a function selector whose reset value is 0000.
// (RULE5) A pin selector is ignored when the mode change input sits there.
// (RULE6) A pin selector is ignored when a travel limit is placed there.
// (RULE7) Limit placement wins over the pin and mode change selectors.
// (RULE8) Forward limit at home pin 6 lets the pin 6 selector win.
// (RULE9) Reverse limit at home pin 7 lets the pin 7 selector win.
// (RULE10) Both limits on one pin keep forward and disable reverse.
// (RULE11) Limit selector: low field forward pin, next reverse, reset 0403.
// (RULE12) Selectors are latched at start-up and on restart only.
`timescale 1ns/1ps
`include "ipsa_defs.vh"

module ipsa_top #(
  parameter NUM_PINS = 4,
  parameter NUM_FUNCS = 16
) (
  clk,
  resetn,
  reg_addr,
  reg_wr_data,
  reg_wr_en,
  reg_rd_en,
  reg_rd_data,
  pin_level,
  speed_mode,
  func_active,
  forward_travel_limit,
  reverse_travel_limit,
  control_change_input
);
  input wire clk;
  input wire resetn;
  input wire [3:0] reg_addr;
  input wire [15:0] reg_wr_data;
  input wire reg_wr_en;
  input wire reg_rd_en;
  output wire [15:0] reg_rd_data;
  input wire [NUM_PINS-1:0] pin_level;
  input wire speed_mode;
  output reg [NUM_FUNCS-1:0] func_active;
  output reg forward_travel_limit;
  output reg reverse_travel_limit;
  output reg control_change_input;

  // Start-up latch sequencer states
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [95:0] active_r;
  reg [NUM_PINS-1:0] pin_r;
  reg [NUM_FUNCS-1:0] func_nxt;
  reg fwd_nxt;
  reg rev_nxt;
  reg chg_nxt;
  wire [95:0] prog_flat;
  wire apply_pulse;
  wire [15:0] status;
  wire [15:0] limit_sel;
  wire [15:0] chg_sel;
  wire [7:0] fwd_pin;
  wire [7:0] rev_pin;
  wire [7:0] chg_pin;
  wire [4*NUM_PINS-1:0] func_code;
  wire [NUM_PINS-1:0] fwd_take;
  wire [NUM_PINS-1:0] rev_take;
  wire [NUM_PINS-1:0] chg_take;
  wire [NUM_PINS-1:0] sel_ignored;
  wire rev_disabled;
  integer i;

  // ************************************************************
  // Register file
  // ************************************************************
  ipsa_regs u_regs (
    .clk(clk),
    .resetn(resetn),
    .addr(reg_addr),
    .wr_data(reg_wr_data),
    .wr_en(reg_wr_en),
    .rd_en(reg_rd_en),
    .status(status),
    .active_flat(active_r),
    .prog_flat(prog_flat),
    .apply_pulse(apply_pulse),
    .rd_data(reg_rd_data)
  );

  // ************************************************************
  // Start-up latch of the selectors
  // ************************************************************
  // Load once after reset release, then only on a restart request
  always @* begin
    case (state_r)
      ST_LOAD: state_nxt = ST_RUN;
      ST_RUN: state_nxt = apply_pulse ? ST_LOAD : ST_RUN;
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      state_r <= ST_LOAD;
    else
      state_r <= state_nxt;
  end

  // Working copies used by the router
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_r <= {`IPSA_RST_CHG, `IPSA_RST_LIMIT, `IPSA_RST_PIN7,
                   `IPSA_RST_PIN6, `IPSA_RST_PIN5, `IPSA_RST_PIN3};
    end else if (state_r == ST_LOAD) begin
      active_r <= prog_flat; // [RULE12]
    end
  end

  // Selected fields of the latched limit and mode change selectors
  assign limit_sel = active_r[`IPSA_REG_LIMIT*16 +: 16];
  assign chg_sel = active_r[`IPSA_REG_CHG*16 +: 16];
  assign fwd_pin = limit_sel[`IPSA_FWD_PIN]; // [RULE11]
  assign rev_pin = limit_sel[`IPSA_REV_PIN]; // [RULE11]
  assign chg_pin = chg_sel[`IPSA_CHG_PIN];
  assign rev_disabled = (rev_pin == fwd_pin) &&
                        (rev_pin != `IPSA_PIN_NONE); // [RULE10]

  // ************************************************************
  // Per-pin resolution
  // ************************************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
      ipsa_route #(
        .PIN_IDX(p)
      ) u_route (
        .sel(active_r[p*16 +: 16]),
        .fwd_pin(fwd_pin),
        .rev_pin(rev_pin),
        .chg_pin(chg_pin),
        .speed_mode(speed_mode),
        .func_code(func_code[p*4 +: 4]),
        .fwd_take(fwd_take[p]),
        .rev_take(rev_take[p]),
        .chg_take(chg_take[p]),
        .sel_ignored(sel_ignored[p])
      );
    end
  endgenerate

  // ************************************************************
  // Pin sampling
  // ************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      pin_r <= {NUM_PINS{`IPSA_LEVEL_IDLE}};
    else
      pin_r <= pin_level;
  end

  // ************************************************************
  // Function and limit combination
  // ************************************************************
  // A pin drives the function its selector names unless claimed
  always @* begin
    func_nxt = {NUM_FUNCS{`IPSA_LEVEL_IDLE}};
    fwd_nxt = `IPSA_LIMIT_IDLE;
    rev_nxt = `IPSA_LIMIT_IDLE;
    chg_nxt = `IPSA_LEVEL_IDLE;
    for (i = 0; i < NUM_PINS; i = i + 1) begin
      if (func_code[i*4 +: 4] != `IPSA_FUNC_NONE)
        func_nxt[func_code[i*4 +: 4]] = func_nxt[func_code[i*4 +: 4]] |
                                        pin_r[i]; // [RULE5] [RULE6]
      if (fwd_take[i])
        fwd_nxt = pin_r[i]; // [RULE7]
      if (rev_take[i])
        rev_nxt = pin_r[i]; // [RULE10]
      if (chg_take[i])
        chg_nxt = pin_r[i];
    end
  end

  // Registered outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      func_active <= {NUM_FUNCS{`IPSA_LEVEL_IDLE}};
      forward_travel_limit <= `IPSA_LIMIT_IDLE;
      reverse_travel_limit <= `IPSA_LIMIT_IDLE;
      control_change_input <= `IPSA_LEVEL_IDLE;
    end else begin
      func_active <= func_nxt;
      forward_travel_limit <= fwd_nxt;
      reverse_travel_limit <= rev_nxt;
      control_change_input <= chg_nxt;
    end
  end

  // ************************************************************
  // Status word
  // ************************************************************
  assign status = {4'h0, (state_r == ST_LOAD), rev_disabled,
                   |chg_take, |rev_take, |fwd_take, 3'h0,
                   sel_ignored};
endmodule

// *** tb/ipsa_wiring.sv ***
// External wiring model: host outputs and limit switches on the connector
`timescale 1ns/1ps
module ipsa_wiring (
  input wire [3:0] cmd_level,
  output wire [3:0] pin_level
);
  // Driven contacts pass the host level straight onto the pins
  assign pin_level = cmd_level;
endmodule

// *** tb/ipsa_chk.sv ***
// Checker for the input pin signal assignment block
`timescale 1ns/1ps
module ipsa_chk #(
  parameter NUM_PINS = 4,
  parameter NUM_FUNCS = 16
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [15:0] reg_rd_data,
  input wire [NUM_PINS-1:0] pin_level,
  input wire speed_mode,
  input wire [NUM_FUNCS-1:0] func_active,
  input wire forward_travel_limit,
  input wire reverse_travel_limit,
  input wire control_change_input
);
  // ************************************************************
  // Helper state: settled after reset, written, applied
  // ************************************************************
  reg [2:0] alive_r;
  reg applied_r;
  reg wrote_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alive_r <= 3'h0;
      applied_r <= 1'b0;
      wrote_r <= 1'b0;
    end else begin
      if (alive_r != 3'h4) alive_r <= alive_r + 3'h1;
      if (reg_wr_en) wrote_r <= 1'b1;
      if (reg_wr_en && reg_addr == 4'h6 && reg_wr_data[0])
        applied_r <= 1'b1;
    end
  end
  wire dflt = alive_r == 3'h4 && !applied_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ************************************************************
  // Assertions
  // ************************************************************
  rd_idle_zero_a: assert property (
    !$past(reg_rd_en) |-> reg_rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  apply_read_zero_a: assert property (
    reg_rd_en && reg_addr == 4'h6 |=> reg_rd_data == 16'h0000)
    else $error("apply word read back not zero");
  pin3_reset_a: assert property (
    reg_rd_en && reg_addr == 4'h0 && !wrote_r |=> reg_rd_data == 16'h0882)
    else $error("pin 3 selector reset value wrong");
  pin5_reset_a: assert property (
    reg_rd_en && reg_addr == 4'h1 && !wrote_r |=> reg_rd_data == 16'h0995)
    else $error("pin 5 selector reset value wrong");
  limit_reset_a: assert property (
    reg_rd_en && reg_addr == 4'h4 && !wrote_r |=> reg_rd_data == 16'h0403)
    else $error("limit selector reset value wrong");
  pos_route_a: assert property (
    dflt && !speed_mode && !$past(speed_mode) && !$past(speed_mode, 2)
    |-> func_active[2] == $past(pin_level[0], 2))
    else $error("pin 3 position function not routed");
  spd_route_a: assert property (
    dflt && (speed_mode && $past(speed_mode)) && $past(speed_mode, 2)
    |-> func_active[9] == $past(pin_level[1], 2))
    else $error("pin 5 speed function not routed");
  home_limits_a: assert property (
    dflt |-> forward_travel_limit && reverse_travel_limit)
    else $error("limit taken from a home pin");
  no_change_a: assert property (
    dflt |-> !control_change_input)
    else $error("mode change input active while unassigned");
  func_none_a: assert property (
    func_active[0] == 1'b0)
    else $error("function code zero reported active");
  apply_c: cover property (reg_wr_en && reg_addr == 4'h6);
  pos_c: cover property (dflt && func_active[2]);
  spd_c: cover property (dflt && func_active[9]);
endmodule
bind ipsa_top ipsa_chk #(.NUM_PINS(NUM_PINS), .NUM_FUNCS(NUM_FUNCS)) u_chk (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .pin_level(pin_level),
  .speed_mode(speed_mode), .func_active(func_active),
  .forward_travel_limit(forward_travel_limit),
  .reverse_travel_limit(reverse_travel_limit),
  .control_change_input(control_change_input));

// *** tb/test_ipsa_top.sv ***
// Self-checking bench for the input pin signal assignment block
`timescale 1ns/1ps
module test_ipsa_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wr_data = 16'h0000;
  reg reg_wr_en = 1'b0;
  reg reg_rd_en = 1'b0;
  reg [3:0] cmd_level = 4'h0;
  reg speed_mode = 1'b0;
  wire [15:0] reg_rd_data;
  wire [3:0] pin_level;
  wire [15:0] func_active;
  wire fwd_lim;
  wire rev_lim;
  wire chg_in;
  wire [18:0] seen_route = {chg_in, rev_lim, fwd_lim, func_active};
  integer n_errors = 0;
  integer tests_run = 0;
  integer i;
  integer k;
  reg [15:0] cur [0:5];
  reg [15:0] tbl [0:29];
  initial forever #10 clk = ~clk;
  ipsa_wiring u_ipsa_wiring (.cmd_level(cmd_level), .pin_level(pin_level));
  ipsa_top u_ipsa_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .pin_level(pin_level), .speed_mode(speed_mode),
    .func_active(func_active), .forward_travel_limit(fwd_lim),
    .reverse_travel_limit(rev_lim), .control_change_input(chg_in));
  // ************************************************************
  // Compare, bus cycles and expected routing
  // ************************************************************
  task check(input [18:0] seen, input [18:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [15:0] want);
    begin
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1 check({3'h0, reg_rd_data}, {3'h0, want});
      @(posedge clk);
    end
  endtask
  function [18:0] model(input [3:0] p, input sm);
    reg [7:0] f, r, c;
    reg [15:0] fa;
    reg fl, rl, cl, fc, rc, cc;
    integer j;
    begin
      f = cur[4][7:0];
      r = cur[4][15:8];
      c = cur[5][7:0];
      if (r == f) r = 8'h00;
      if (f == 8'h03) f = 8'h00;
      if (r == 8'h04) r = 8'h00;
      fa = 16'h0000;
      fl = 1'b1;
      rl = 1'b1;
      cl = 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
        fc = f == j + 1;
        rc = r == j + 1;
        cc = c == j + 1 && !fc && !rc;
        if (fc) fl = p[j];
        if (rc) rl = p[j];
        if (cc) cl = p[j];
        if (!fc && !rc && !cc && p[j])
          fa[sm ? cur[j][7:4] : cur[j][3:0]] = 1'b1;
      end
      fa[0] = 1'b0;
      model = {cl, rl, fl, fa};
    end
  endfunction
  // Expected status word from the latched limit and mode change words
  function [15:0] stat_of(input [15:0] lim, input [7:0] c);
    reg [7:0] f, r;
    reg fc, rc, cc;
    integer j;
    begin
      f = lim[7:0];
      r = lim[15:8];
      stat_of = 16'h0000;
      stat_of[10] = r == f && r != 8'h00;
      if (r == f) r = 8'h00;
      if (f == 8'h03) f = 8'h00;
      if (r == 8'h04) r = 8'h00;
      for (j = 0; j < 4; j = j + 1) begin
        fc = f == j + 1;
        rc = r == j + 1;
        cc = c == j + 1 && !fc && !rc;
        stat_of[j] = fc | rc | cc;
        stat_of[7] = stat_of[7] | fc;
        stat_of[8] = stat_of[8] | rc;
        stat_of[9] = stat_of[9] | cc;
      end
    end
  endfunction
  task route(input integer n);
    integer m;
    reg [31:0] v;
    begin
      for (m = 0; m < n; m = m + 1) begin
        v = $urandom;
        cmd_level <= (m == 0) ? 4'hf : v[3:0];
        speed_mode <= v[4];
        repeat (3) @(posedge clk);
        #1 check(seen_route, model(cmd_level, speed_mode));
        @(posedge clk);
      end
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    #200000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    tbl = '{16'h0882, 16'h0995, 16'h0000, 16'h0000, 16'h0403, 16'h0000,
      16'h0011, 16'h0022, 16'h00c3, 16'h00e7, 16'h0201, 16'h0004,
      16'h0031, 16'h00a2, 16'h0056, 16'h00b7, 16'h0202, 16'h0002,
      16'h0882, 16'h0995, 16'h0074, 16'h00e1, 16'h0403, 16'h0000,
      16'h00d1, 16'h0042, 16'h00f3, 16'h0065, 16'h0304, 16'h0001};
    for (k = 0; k < 6; k = k + 1) cur[k] = tbl[k];
    i = $urandom(34217);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i = i + 1) begin
      rd(i[3:0], cur[i]);
      rd(i[3:0] + 4'h8, cur[i]);
    end
    rd(4'h6, 16'h0000);
    rd(4'hf, 16'h0000);
    route(20);
    rd(4'h7, stat_of(cur[4], cur[5][7:0]));
    $display("test reset values and default routing done");
    for (i = 1; i < 5; i = i + 1) begin
      for (k = 0; k < 6; k = k + 1) wr(k[3:0], tbl[i * 6 + k]);
      rd(4'hc, cur[4]);
      route(4);
      for (k = 0; k < 6; k = k + 1) cur[k] = tbl[i * 6 + k];
      wr(4'h6, 16'h0001);
      repeat (4) @(posedge clk);
      rd(4'hc, cur[4]);
      route(12);
      rd(4'h7, stat_of(cur[4], cur[5][7:0]));
      $display("test assignment set %0d done", i);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 6; k = k + 1) cur[k] = tbl[k];
    rd(4'h4, 16'h0403);
    route(8);
    $display("test second reset done");
    summarize;
  end
endmodule
